// ===== hdl/sphp_pkg.sv
//----------------------------------------------------------------------
// Purpose: Constants and types of the strobed parallel handshake port
// Assumes: 32-bit Avalon-MM register bus, 8-bit ports
// Notes: Offsets are byte addresses of aligned words
//----------------------------------------------------------------------
package sphp_pkg;

   //-------------------------------------------------------------------
   // Register offsets
   //-------------------------------------------------------------------
   localparam logic [4:0] OFS_PORT_A = 5'h00;
   localparam logic [4:0] OFS_PORT_B = 5'h04;
   localparam logic [4:0] OFS_FLAGS = 5'h08;
   localparam logic [4:0] OFS_CTRL = 5'h0C;

   //-------------------------------------------------------------------
   // Control word fields
   //-------------------------------------------------------------------
   localparam int CW_MODE_BIT = 7;
   localparam int CW_IDX_LSB = 1;
   localparam int CW_IDX_MSB = 3;
   localparam int CW_VAL_BIT = 0;

   //-------------------------------------------------------------------
   // Handshake line positions
   //-------------------------------------------------------------------
   localparam int HL_IRQ_B = 0;
   localparam int HL_FULL_B = 1;
   localparam int HL_STB_B = 2;
   localparam int HL_IRQ_A = 3;
   localparam int HL_STB_A = 4;
   localparam int HL_IBF_A = 5;
   localparam int HL_ACK_A = 6;
   localparam int HL_OBF_A = 7;

   //-------------------------------------------------------------------
   // Reset values and vectors
   //-------------------------------------------------------------------
   localparam logic [6:0] MODE_RST = 7'h12;
   localparam logic [7:0] HL_RST = 8'hFF;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] VEC_A = 8'h5C;
   localparam logic [7:0] VEC_B = 8'h58;
   localparam logic [7:0] VEC_NONE = 8'h00;

   //-------------------------------------------------------------------
   // Types
   //-------------------------------------------------------------------
   typedef struct packed {
      logic a_mode2;
      logic a_mode1;
      logic a_in;
      logic pcu_in;
      logic b_mode1;
      logic b_in;
      logic pcl_in;
   } sphp_mode_t;

   typedef struct packed {
      logic ibf_a;
      logic obf_a_n;
      logic acc_a;
      logic ibf_b;
      logic obf_b_n;
      logic acc_b;
   } sphp_flags_t;

   localparam sphp_flags_t FLAGS_IDLE = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

endpackage

// ===== hdl/sphp_port.sv
//----------------------------------------------------------------------
// Purpose: Strobed parallel port, handshake and flag logic
// Assumes: Peripheral pins are asynchronous and pass two flip-flops
// Notes: Flag register is read-back of the handshake lines
//----------------------------------------------------------------------
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
module sphp_port
   import sphp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Avalon-MM slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Port A pins
   input wire logic [7:0] port_a_i,
   output logic [7:0] port_a_o,
   output logic port_a_oe_o,
   // Port B pins
   input wire logic [7:0] port_b_i,
   output logic [7:0] port_b_o,
   output logic port_b_oe_o,
   // Handshake lines
   input wire logic [7:0] hl_i,
   output logic [7:0] hl_o,
   output logic [7:0] hl_oe_o,
   // Interrupt requests
   output logic irq_a_o,
   output logic irq_b_o,
   output logic [7:0] irq_vector_o
);

   //-------------------------------------------------------------------
   // Input synchronisers
   //-------------------------------------------------------------------
   logic [7:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
   logic [7:0] hl_s1_ff, hl_s2_ff, hl_d_ff;
   logic [7:0] fall;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pa_s1_ff <= 8'h00;
         pa_s2_ff <= 8'h00;
         pb_s1_ff <= 8'h00;
         pb_s2_ff <= 8'h00;
         hl_s1_ff <= 8'hFF;
         hl_s2_ff <= 8'hFF;
         hl_d_ff <= 8'hFF;
      end else begin
         pa_s1_ff <= port_a_i;
         pa_s2_ff <= pa_s1_ff;
         pb_s1_ff <= port_b_i;
         pb_s2_ff <= pb_s1_ff;
         hl_s1_ff <= hl_i;
         hl_s2_ff <= hl_s1_ff;
         hl_d_ff <= hl_s2_ff;
      end
   end

   // Strobe and accept are active low; an event is the falling edge
   assign fall = hl_d_ff & ~hl_s2_ff;

   //-------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------
   sphp_mode_t mode_ff, nxt_mode;
   sphp_flags_t flg_ff, nxt_flg;
   logic [7:0] latch_ff, nxt_latch;
   logic [7:0] in_a_ff, nxt_in_a, in_b_ff, nxt_in_b;
   logic [7:0] out_a_ff, nxt_out_a, out_b_ff, nxt_out_b;
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] hl_o_ff, nxt_hl_o, hl_oe_ff, nxt_hl_oe;
   logic pa_oe_ff, nxt_pa_oe, pb_oe_ff, nxt_pb_oe;
   logic irq_a_ff, nxt_irq_a, irq_b_ff, nxt_irq_b;
   logic [7:0] vec_ff, nxt_vec;

   logic req, look, go, wr_ok;
   logic a_in_hs, a_out_hs, b_in_hs, b_out_hs, a_m1;
   logic rd_a, wr_a, rd_b, wr_b, wr_ctrl;
   logic busy_a, busy_b;
   logic [7:0] hl_val, rd_fl;
   logic [2:0] idx;

   always_comb begin
      req = avs_read_i | avs_write_i;
      look = req & wait_ff;
      go = req & ~wait_ff;
      wr_ok = avs_write_i & avs_byteenable_i[0];
      a_m1 = mode_ff.a_mode1 & ~mode_ff.a_mode2;
      a_in_hs = mode_ff.a_mode2 | (a_m1 & mode_ff.a_in);
      a_out_hs = mode_ff.a_mode2 | (a_m1 & ~mode_ff.a_in);
      b_in_hs = mode_ff.b_mode1 & mode_ff.b_in;
      b_out_hs = mode_ff.b_mode1 & ~mode_ff.b_in;
      rd_a = 1'b0;
      wr_a = 1'b0;
      rd_b = 1'b0;
      wr_b = 1'b0;
      wr_ctrl = 1'b0;
      busy_a = 1'b0;
      busy_b = 1'b0;
      // Address decode; direct writes to the flag register are dropped
      if (avs_address_i == OFS_PORT_A) begin
         rd_a = go & avs_read_i;
         wr_a = go & wr_ok;
         busy_a = look;
      end else if (avs_address_i == OFS_PORT_B) begin
         rd_b = go & avs_read_i;
         wr_b = go & wr_ok;
         busy_b = look;
      end else if (avs_address_i == OFS_CTRL) begin
         wr_ctrl = go & wr_ok;
      end
      nxt_wait = ~look;
      nxt_mode = mode_ff;
      nxt_latch = latch_ff;
      nxt_flg = flg_ff;
      nxt_in_a = in_a_ff;
      nxt_in_b = in_b_ff;
      nxt_out_a = out_a_ff;
      nxt_out_b = out_b_ff;
      idx = avs_writedata_i[CW_IDX_MSB:CW_IDX_LSB];
      if (wr_ctrl) begin
         if (avs_writedata_i[CW_MODE_BIT]) begin
            nxt_mode = sphp_mode_t'(avs_writedata_i[6:0]);
            nxt_flg = FLAGS_IDLE;
         end else begin
            nxt_latch[idx] = avs_writedata_i[CW_VAL_BIT];
         end
      end
      // Clears first, so that a strobe or accept in the same cycle wins
      if (rd_a) nxt_flg.ibf_a = 1'b0;
      if (wr_a) begin
         nxt_out_a = avs_writedata_i[7:0];
         if (a_out_hs) begin
            nxt_flg.obf_a_n = 1'b0;
            nxt_flg.acc_a = 1'b0;
         end
      end
      if (rd_b) nxt_flg.ibf_b = 1'b0;
      if (wr_b) begin
         nxt_out_b = avs_writedata_i[7:0];
         if (b_out_hs) begin
            nxt_flg.obf_b_n = 1'b0;
            nxt_flg.acc_b = 1'b0;
         end
      end
      if (a_in_hs && fall[HL_STB_A]) begin
         nxt_in_a = pa_s2_ff;
         nxt_flg.ibf_a = 1'b1;
      end
      if (a_out_hs && fall[HL_ACK_A]) begin
         nxt_flg.obf_a_n = 1'b1;
         nxt_flg.acc_a = 1'b1;
      end
      if (b_in_hs && fall[HL_STB_B]) begin
         nxt_in_b = pb_s2_ff;
         nxt_flg.ibf_b = 1'b1;
      end
      if (b_out_hs && fall[HL_STB_B]) begin
         nxt_flg.obf_b_n = 1'b1;
         nxt_flg.acc_b = 1'b1;
      end
      // Requests, gated by their enable lines
      nxt_irq_a = (a_in_hs & nxt_flg.ibf_a & nxt_latch[HL_STB_A])
         | (a_out_hs & nxt_flg.acc_a & nxt_latch[HL_ACK_A]);
      nxt_irq_b = mode_ff.b_mode1 & nxt_latch[HL_STB_B]
         & (mode_ff.b_in ? nxt_flg.ibf_b : nxt_flg.acc_b);
      if (nxt_irq_a) nxt_vec = VEC_A;
      else if (nxt_irq_b) nxt_vec = VEC_B;
      else nxt_vec = VEC_NONE;
      // Line values; lamp and direction bits come straight from the latch
      hl_val = nxt_latch;
      if (mode_ff.b_mode1) begin
         hl_val[HL_IRQ_B] = nxt_irq_b;
         hl_val[HL_FULL_B] = mode_ff.b_in ? nxt_flg.ibf_b : (nxt_flg.obf_b_n | busy_b);
      end
      if (a_in_hs | a_out_hs) hl_val[HL_IRQ_A] = nxt_irq_a;
      if (a_in_hs) hl_val[HL_IBF_A] = nxt_flg.ibf_a;
      if (a_out_hs) hl_val[HL_OBF_A] = nxt_flg.obf_a_n | busy_a;
      nxt_hl_o = hl_val;
      // Line directions
      nxt_hl_oe = {{4{~mode_ff.pcu_in}}, ~mode_ff.pcl_in, 1'b0, {2{~mode_ff.pcl_in}}};
      if (mode_ff.b_mode1) nxt_hl_oe[1:0] = 2'b11;
      if (a_in_hs | a_out_hs) nxt_hl_oe[HL_IRQ_A] = 1'b1;
      if (mode_ff.a_mode2) begin
         nxt_hl_oe[7:4] = 4'b1010;
      end else if (a_in_hs) begin
         nxt_hl_oe[HL_STB_A] = 1'b0;
         nxt_hl_oe[HL_IBF_A] = 1'b1;
      end else if (a_out_hs) begin
         nxt_hl_oe[HL_ACK_A] = 1'b0;
         nxt_hl_oe[HL_OBF_A] = 1'b1;
      end
      // Port buffers
      if (mode_ff.a_mode2) nxt_pa_oe = ~hl_s2_ff[HL_ACK_A];
      else nxt_pa_oe = ~mode_ff.a_in;
      if (a_m1 && mode_ff.a_in && !mode_ff.pcu_in) nxt_pb_oe = ~nxt_latch[HL_ACK_A];
      else nxt_pb_oe = ~mode_ff.b_in;
      // Read-back of the flag register shows enables where they live
      rd_fl = (hl_oe_ff & hl_o_ff) | (~hl_oe_ff & hl_s2_ff);
      if (a_in_hs) rd_fl[HL_STB_A] = latch_ff[HL_STB_A];
      if (a_out_hs) rd_fl[HL_ACK_A] = latch_ff[HL_ACK_A];
      if (mode_ff.b_mode1) rd_fl[HL_STB_B] = latch_ff[HL_STB_B];
      // Upper bits read as zero; control word is write-only
      nxt_rdata = rdata_ff;
      if (look) begin
         nxt_rdata = 32'h0000_0000;
         if (avs_address_i == OFS_PORT_A) begin
            if (a_in_hs) nxt_rdata[7:0] = in_a_ff;
            else if (mode_ff.a_in) nxt_rdata[7:0] = pa_s2_ff;
            else nxt_rdata[7:0] = out_a_ff;
         end else if (avs_address_i == OFS_PORT_B) begin
            if (b_in_hs) nxt_rdata[7:0] = in_b_ff;
            else if (mode_ff.b_in) nxt_rdata[7:0] = pb_s2_ff;
            else nxt_rdata[7:0] = out_b_ff;
         end else if (avs_address_i == OFS_FLAGS) begin
            nxt_rdata[7:0] = rd_fl;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_ff <= sphp_mode_t'(MODE_RST);
         flg_ff <= FLAGS_IDLE;
         latch_ff <= HL_RST;
         in_a_ff <= DATA_RST;
         in_b_ff <= DATA_RST;
         out_a_ff <= DATA_RST;
         out_b_ff <= DATA_RST;
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
         hl_o_ff <= HL_RST;
         hl_oe_ff <= 8'hFF;
         pa_oe_ff <= 1'b0;
         pb_oe_ff <= 1'b0;
         irq_a_ff <= 1'b0;
         irq_b_ff <= 1'b0;
         vec_ff <= VEC_NONE;
      end else begin
         mode_ff <= nxt_mode;
         flg_ff <= nxt_flg;
         latch_ff <= nxt_latch;
         in_a_ff <= nxt_in_a;
         in_b_ff <= nxt_in_b;
         out_a_ff <= nxt_out_a;
         out_b_ff <= nxt_out_b;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         hl_o_ff <= nxt_hl_o;
         hl_oe_ff <= nxt_hl_oe;
         pa_oe_ff <= nxt_pa_oe;
         pb_oe_ff <= nxt_pb_oe;
         irq_a_ff <= nxt_irq_a;
         irq_b_ff <= nxt_irq_b;
         vec_ff <= nxt_vec;
      end
   end

   assign avs_readdata_o = rdata_ff;
   assign avs_waitrequest_o = wait_ff;
   assign port_a_o = out_a_ff;
   assign port_a_oe_o = pa_oe_ff;
   assign port_b_o = out_b_ff;
   assign port_b_oe_o = pb_oe_ff;
   assign hl_o = hl_o_ff;
   assign hl_oe_o = hl_oe_ff;
   assign irq_a_o = irq_a_ff;
   assign irq_b_o = irq_b_ff;
   assign irq_vector_o = vec_ff;

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence bus_answer_s;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   bus_timing_a: assert property (look |=> bus_answer_s)
      else $error("bus answer not one wait cycle");
   read_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   ibf_set_a: assert property (a_in_hs && fall[HL_STB_A] && !wr_ctrl |=> hl_o[HL_IBF_A] && flg_ff.ibf_a)
      else $error("input full A not set by strobe");
   ibf_clear_a: assert property (rd_a && !fall[HL_STB_A] && a_in_hs |=> !flg_ff.ibf_a && !irq_a_o)
      else $error("input full A not cleared by read");
   obf_write_a: assert property (wr_a && a_out_hs && !fall[HL_ACK_A] |=> !hl_o[HL_OBF_A] && !flg_ff.acc_a)
      else $error("output full A not lowered by write");
   obf_access_a: assert property (look && avs_address_i == OFS_PORT_A && a_out_hs |=> hl_o[HL_OBF_A])
      else $error("output full A not negated during access");
   irq_gate_a: assert property (!nxt_latch[HL_STB_A] && !nxt_latch[HL_ACK_A] |=> !irq_a_o)
      else $error("port A request not gated");
   irq_gate_b: assert property (mode_ff.b_mode1 && !nxt_latch[HL_STB_B] |=> !irq_b_o && !hl_o[HL_IRQ_B])
      else $error("port B request not gated");
   mode2_drive_a: assert property (mode_ff.a_mode2 && hl_s2_ff[HL_ACK_A] |=> !port_a_oe_o)
      else $error("port A driven without accept");
   bitset_a: assert property (wr_ctrl && !avs_writedata_i[CW_MODE_BIT] |=> latch_ff[$past(idx)] == $past(avs_writedata_i[0]))
      else $error("bit set word not applied");
   vector_a: assert property (irq_a_o |-> irq_vector_o == VEC_A)
      else $error("port A vector wrong");
   b_accept_a: assert property (b_out_hs && fall[HL_STB_B] && !wr_ctrl |=> hl_o[HL_FULL_B] && flg_ff.acc_b)
      else $error("output full B not raised by accept");
   vector_b_a: assert property (irq_b_o && !irq_a_o |-> irq_vector_o == VEC_B)
      else $error("port B vector wrong");
   vector_idle_a: assert property (!irq_a_o && !irq_b_o |-> irq_vector_o == VEC_NONE)
      else $error("vector set without request");
   irq_line_a: assert property (a_in_hs || a_out_hs |=> hl_o[HL_IRQ_A] == irq_a_o)
      else $error("port A request line differs");

endmodule // sphp_port

// ===== tb/sphp_periph.sv
//----------------------------------------------------------------------
// Purpose: Peripheral model on the parallel connector
// Assumes: Handshake lines idle high through pull-ups
// Notes: Released data lines show the inverse of the last value
//----------------------------------------------------------------------
module sphp_periph (
   // Clock
   input wire logic sys_clk_i,
   // Device outputs
   input wire logic [7:0] port_a_o,
   input wire logic port_a_oe_o,
   input wire logic [7:0] port_b_o,
   input wire logic port_b_oe_o,
   input wire logic [7:0] hl_o,
   input wire logic [7:0] hl_oe_o,
   // Pin levels
   output logic [7:0] port_a_i,
   output logic [7:0] port_b_i,
   output logic [7:0] hl_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] low_ff = 8'h00;
   logic [7:0] val_ff = 8'h00;
   logic drv_ff = 1'b0;
   //-------------------------------------------------------------------
   // Wired levels
   //-------------------------------------------------------------------
   assign hl_i = ((hl_oe_o & hl_o) | ~hl_oe_o) & ~low_ff;
   assign port_a_i = port_a_oe_o ? port_a_o : (drv_ff ? val_ff : ~val_ff);
   assign port_b_i = port_b_oe_o ? port_b_o : (drv_ff ? val_ff : ~val_ff);
   //-------------------------------------------------------------------
   // Pulses
   //-------------------------------------------------------------------
   // Low for 3 clocks, above the 2-clock minimum, data held around it
   task automatic pulse(input int idx, input logic [7:0] data);
      @(posedge sys_clk_i);
      val_ff <= data;
      drv_ff <= 1'b1;
      @(posedge sys_clk_i);
      low_ff[idx] <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      low_ff[idx] <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      drv_ff <= 1'b0;
   endtask
   // Accept held low; data bus left to the device meanwhile
   task automatic hold(input int idx, input logic lvl);
      @(posedge sys_clk_i);
      low_ff[idx] <= lvl;
   endtask
endmodule // sphp_periph

// ===== tb/tb_strobed_parallel_handshake_port.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench of the strobed parallel handshake port
// Assumes: One access at a time on the register bus
// Notes: Bus answers are taken at the rising edge that samples waitrequest low
//----------------------------------------------------------------------
module tb_strobed_parallel_handshake_port
   import sphp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic arst_n_i;
   logic [4:0] avs_address_i;
   logic avs_read_i, avs_write_i;
   logic [3:0] avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic avs_waitrequest_o, port_a_oe_o, port_b_oe_o, irq_a_o, irq_b_o, obf;
   logic [7:0] port_a_i, port_a_o, port_b_i, port_b_o, hl_i, hl_o, hl_oe_o, irq_vector_o;
   int mismatches = 0;
   int cmp_count = 0;
   int n;
   always #12.5 sys_clk_i = ~sys_clk_i;
   sphp_port i_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .port_a_i(port_a_i), .port_a_o(port_a_o),
      .port_a_oe_o(port_a_oe_o), .port_b_i(port_b_i), .port_b_o(port_b_o), .port_b_oe_o(port_b_oe_o),
      .hl_i(hl_i), .hl_o(hl_o), .hl_oe_o(hl_oe_o), .irq_a_o(irq_a_o), .irq_b_o(irq_b_o),
      .irq_vector_o(irq_vector_o));
   sphp_periph i_per (.sys_clk_i(sys_clk_i), .port_a_o(port_a_o), .port_a_oe_o(port_a_oe_o),
      .port_b_o(port_b_o), .port_b_oe_o(port_b_oe_o), .hl_o(hl_o), .hl_oe_o(hl_oe_o),
      .port_a_i(port_a_i), .port_b_i(port_b_i), .hl_i(hl_i));
   //-------------------------------------------------------------------
   // Tasks
   //-------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic gap(input int k);
      repeat (k) @(negedge sys_clk_i);
   endtask
   // Request held until the edge at which waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge sys_clk_i);
      avs_address_i <= adr;
      avs_writedata_i <= {24'h000000, wd};
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      // Values read here are those that stood at this edge, before its updates
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         k++;
         if (k > 20) begin
            mismatches++;
            tally_and_finish();
         end
         @(posedge sys_clk_i);
      end
      rd = avs_readdata_o;
      obf = hl_o[HL_OBF_A];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   function automatic logic [7:0] bw(input int idx, input logic v);
      return {4'h0, 3'(idx), v};
   endfunction
   //-------------------------------------------------------------------
   // Sequence
   //-------------------------------------------------------------------
   initial begin
      arst_n_i = 1'b0;
      avs_address_i = 5'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_byteenable_i = 4'hF;
      avs_writedata_i = 32'h00000000;
      repeat (2) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      gap(1);
      chk(hl_o, HL_RST);
      chk(8'({port_a_oe_o, port_b_oe_o}), 8'h00);
      bus(1'b1, OFS_FLAGS, 8'h00);
      gap(2);
      chk(hl_o, HL_RST);
      bus(1'b0, OFS_FLAGS, 8'h00);
      chk(rd[15:8], 8'h00);
      bus(1'b0, 5'h10, 8'h00);
      chk(rd[7:0], 8'h00);
      // Mode 1, both ports input, line halves output
      bus(1'b1, OFS_CTRL, 8'hB6);
      bus(1'b1, OFS_CTRL, bw(HL_STB_A, 1'b1));
      bus(1'b1, OFS_CTRL, bw(HL_STB_B, 1'b1));
      i_per.pulse(HL_STB_A, 8'hA5);
      chk(8'(hl_o[HL_IBF_A]), 8'h01);
      chk(8'(irq_a_o), 8'h01);
      chk(hl_oe_o, 8'hEB);
      chk(irq_vector_o, VEC_A);
      bus(1'b0, OFS_PORT_A, 8'h00);
      chk(rd[7:0], 8'hA5);
      gap(2);
      chk(8'({hl_o[HL_IBF_A], irq_a_o}), 8'h00);
      bus(1'b1, OFS_CTRL, bw(HL_STB_A, 1'b0));
      i_per.pulse(HL_STB_A, 8'h5A);
      chk(8'({hl_o[HL_IBF_A], irq_a_o}), 8'h02);
      bus(1'b0, OFS_PORT_A, 8'h00);
      i_per.pulse(HL_STB_B, 8'hC3);
      chk(8'({hl_o[HL_FULL_B], irq_b_o}), 8'h03);
      chk(irq_vector_o, VEC_B);
      bus(1'b0, OFS_PORT_B, 8'h00);
      chk(rd[7:0], 8'hC3);
      gap(2);
      chk(8'({hl_o[HL_FULL_B], irq_b_o}), 8'h00);
      bus(1'b1, OFS_CTRL, bw(HL_STB_B, 1'b0));
      i_per.pulse(HL_STB_B, 8'h11);
      chk(8'({hl_o[HL_FULL_B], irq_b_o, hl_o[HL_IRQ_B]}), 8'h04);
      bus(1'b0, OFS_PORT_B, 8'h00);
      chk(rd[7:0], 8'h11);
      for (n = 0; n < 2; n++) begin
         bus(1'b1, OFS_CTRL, bw(HL_OBF_A, n[0]));
         bus(1'b1, OFS_CTRL, bw(HL_ACK_A, n[0]));
         gap(2);
         chk(8'(hl_o[HL_OBF_A]), 8'(n));
         chk(8'(port_b_oe_o), 8'(1 - n));
      end
      // Mode 1, both ports output
      bus(1'b1, OFS_CTRL, 8'hA4);
      bus(1'b1, OFS_CTRL, bw(HL_ACK_A, 1'b1));
      bus(1'b1, OFS_CTRL, bw(HL_STB_B, 1'b1));
      bus(1'b1, OFS_PORT_A, 8'h3C);
      gap(2);
      chk(8'(hl_o[HL_OBF_A]), 8'h00);
      chk(port_a_o, 8'h3C);
      bus(1'b0, OFS_PORT_A, 8'h00);
      chk(8'(obf), 8'h01);
      gap(2);
      chk(8'(hl_o[HL_OBF_A]), 8'h00);
      i_per.pulse(HL_ACK_A, 8'h00);
      chk(8'({hl_o[HL_OBF_A], irq_a_o}), 8'h03);
      bus(1'b1, OFS_PORT_A, 8'h3D);
      gap(2);
      chk(8'(irq_a_o), 8'h00);
      bus(1'b1, OFS_PORT_B, 8'h81);
      gap(2);
      chk(8'(hl_o[HL_FULL_B]), 8'h00);
      chk(port_b_o, 8'h81);
      i_per.pulse(HL_STB_B, 8'h00);
      chk(8'({hl_o[HL_FULL_B], irq_b_o}), 8'h03);
      bus(1'b1, OFS_PORT_B, 8'h82);
      gap(2);
      chk(8'(irq_b_o), 8'h00);
      // Mode 2 on port A
      bus(1'b1, OFS_CTRL, 8'hC0);
      bus(1'b1, OFS_CTRL, bw(HL_ACK_A, 1'b1));
      bus(1'b1, OFS_CTRL, bw(HL_STB_A, 1'b1));
      bus(1'b1, OFS_PORT_A, 8'h96);
      gap(2);
      chk(8'({hl_o[HL_OBF_A], port_a_oe_o}), 8'h00);
      chk(hl_oe_o, 8'hAB);
      i_per.hold(HL_ACK_A, 1'b1);
      n = 0;
      while (port_a_oe_o !== 1'b1 && n < 10) begin
         gap(1);
         n++;
      end
      chk(8'(port_a_oe_o), 8'h01);
      chk(port_a_o, 8'h96);
      gap(2);
      chk(8'({hl_o[HL_OBF_A], irq_a_o, hl_o[HL_IRQ_A]}), 8'h07);
      i_per.hold(HL_ACK_A, 1'b0);
      gap(6);
      chk(8'(port_a_oe_o), 8'h00);
      bus(1'b1, OFS_CTRL, bw(HL_ACK_A, 1'b0));
      gap(2);
      chk(8'(irq_a_o), 8'h00);
      i_per.pulse(HL_STB_A, 8'h21);
      chk(8'({hl_o[HL_IBF_A], irq_a_o, hl_o[HL_IRQ_A]}), 8'h07);
      bus(1'b0, OFS_PORT_A, 8'h00);
      chk(rd[7:0], 8'h21);
      gap(2);
      chk(8'(hl_o[HL_IBF_A]), 8'h00);
      tally_and_finish();
   end
endmodule // tb_strobed_parallel_handshake_port
